// ===== shared/ctl_line_pkg.sv
// Constants for the sixteen-line output latch
`default_nettype none
package ctl_line_pkg;
  localparam int          BYTE_W          = 8;
  localparam int          LINE_COUNT      = 16;
  localparam logic [7:0]  DEV_ADDR_RESET  = 8'h71;
  localparam logic [15:0] LINES_RESET     = 16'h0000;
  localparam int          UPPER_LSB       = 8;
  localparam int          LOWER_LSB       = 0;
  localparam int          SYNC_STAGES     = 2;
  localparam int          REPLY_CYCLES    = 2;
  localparam int          CLK_PERIOD_NS   = 25;
endpackage
`default_nettype wire

// ===== rtl/strobe_sync.sv
// Two-stage synchroniser with rising-edge pulse for one strobe
`default_nettype none
module strobe_sync
  import ctl_line_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic strobe_in,
  output logic      level_out,
  output logic      rise_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= strobe_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out  = sync_reg;
  assign rise_pulse = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

// ===== rtl/output_latch.sv
// Sixteen-line latched output port on the processor parallel I/O bus
// Contract
// - Output command resets steering to upper byte
// - Output command clears all sixteen line registers
// - Initialize resets steering and clears lines
// - First write after reset loads upper byte
// - Second consecutive write loads lower byte
// - Steering returns upper after second write
// - Lines hold steady until next write or output command
// - Stored one grounds line, zero releases
// - No status byte is ever returned
// - Bus data is only taken in, as address or write data; no read path
// - Never raises an interrupt request
// - Device number strap-selectable, default 71 hex
// - Each line has its own storage flip-flop
// - Matching address strobe sets module selected
// - Each selected data strobe returns sync, latches unless an output command coincides
// - System clear deselects the module
`default_nettype none
module output_latch
  import ctl_line_pkg::*;
#(
  parameter int             LINES    = LINE_COUNT,
  parameter logic [7:0]     DEV_ADDR = DEV_ADDR_RESET
)
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [7:0]       dev_addr_strap,
  input  wire logic             address_strobe,
  input  wire logic             data_avail_strobe,
  input  wire logic             cmd_strobe,
  input  wire logic [7:0]       bus_data_line,
  output logic                  sync_reply,
  output logic                  irq_req,
  output logic [7:0]            status_byte,
  output logic [LINES-1:0]      output_line_o,
  output logic [LINES-1:0]      output_line_oe_n
);
  // ********************************************************
  // Input synchronisation
  // ********************************************************
  logic adr_rise;
  logic dav_rise;
  logic cmd_rise;
  logic [7:0] data_meta_reg;
  logic [7:0] data_sync_reg;
  logic [7:0] strap_meta_reg;
  logic [7:0] strap_sync_reg;
  logic [7:0] dev_num_reg;
  logic [1:0] strap_wait_reg;
  logic       strap_taken_reg;

  strobe_sync u_adr (
    .core_clk   (core_clk),
    .rst        (rst),
    .strobe_in  (address_strobe),
    .level_out  (),
    .rise_pulse (adr_rise)
  );
  strobe_sync u_dav (
    .core_clk   (core_clk),
    .rst        (rst),
    .strobe_in  (data_avail_strobe),
    .level_out  (),
    .rise_pulse (dav_rise)
  );
  strobe_sync u_cmd (
    .core_clk   (core_clk),
    .rst        (rst),
    .strobe_in  (cmd_strobe),
    .level_out  (),
    .rise_pulse (cmd_rise)
  );

  // Data settles before the strobe edge is seen, so two stages are enough
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_meta_reg  <= 8'h00;
      data_sync_reg  <= 8'h00;
      strap_meta_reg <= 8'h00;
      strap_sync_reg <= 8'h00;
    end
    else
    begin
      data_meta_reg  <= bus_data_line;
      data_sync_reg  <= data_meta_reg;
      strap_meta_reg <= dev_addr_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ********************************************************
  // Device number strap, caught after reset release
  // ********************************************************
  // Wait until the strap has crossed both stages, else zero is taken
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dev_num_reg     <= DEV_ADDR;
      strap_wait_reg  <= 2'd0;
      strap_taken_reg <= 1'b0;
    end
    else if (strap_wait_reg != 2'(SYNC_STAGES))
    begin
      strap_wait_reg <= strap_wait_reg + 2'd1;
    end
    else if (!strap_taken_reg)
    begin
      dev_num_reg     <= strap_sync_reg;
      strap_taken_reg <= 1'b1;
    end
  end

  // ********************************************************
  // Selection and steering
  // ********************************************************
  logic             selected_reg;
  logic             selected_next;
  logic             lower_sel_reg;
  logic             lower_sel_next;
  logic [LINES-1:0] lines_reg;
  logic [LINES-1:0] lines_next;
  logic [1:0]       reply_cnt_reg;
  logic [1:0]       reply_cnt_next;
  logic             addr_match;
  logic             write_hit;
  logic             cmd_hit;
  logic             upper_byte_gate;
  logic             lower_byte_gate;

  assign addr_match      = (data_sync_reg == dev_num_reg);
  assign write_hit       = dav_rise & selected_reg;
  assign cmd_hit         = cmd_rise & selected_reg;
  assign upper_byte_gate = write_hit & ~lower_sel_reg & ~cmd_hit;
  assign lower_byte_gate = write_hit & lower_sel_reg & ~cmd_hit;

  // Match or mismatch decides selection on every address strobe
  assign selected_next = adr_rise ? addr_match : selected_reg;

  // Command wins over a coincident write: the pair restarts
  assign lower_sel_next = cmd_hit ? 1'b0 :
                          upper_byte_gate ? 1'b1 :
                          lower_byte_gate ? 1'b0 :
                          lower_sel_reg;

  always_comb
  begin
    lines_next = lines_reg;
    if (cmd_hit)
      lines_next = LINES_RESET;
    else if (upper_byte_gate)
      lines_next[UPPER_LSB +: BYTE_W] = data_sync_reg;
    else if (lower_byte_gate)
      lines_next[LOWER_LSB +: BYTE_W] = data_sync_reg;
  end

  // Reply stands two cycles so a slow sampler still sees it
  assign reply_cnt_next = write_hit ? 2'(REPLY_CYCLES) :
                          (reply_cnt_reg != 2'd0) ? reply_cnt_reg - 2'd1 : 2'd0;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      selected_reg  <= 1'b0;
      lower_sel_reg <= 1'b0;
      lines_reg     <= LINES_RESET;
      reply_cnt_reg <= 2'd0;
    end
    else
    begin
      selected_reg  <= selected_next;
      lower_sel_reg <= lower_sel_next;
      lines_reg     <= lines_next;
      reply_cnt_reg <= reply_cnt_next;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // Open-collector: a one conducts (drive low), a zero floats
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_reply       <= 1'b0;
      irq_req          <= 1'b0;
      status_byte      <= 8'h00;
      output_line_o    <= '0;
      output_line_oe_n <= '1;
    end
    else
    begin
      sync_reply       <= (reply_cnt_next != 2'd0);
      irq_req          <= 1'b0;
      status_byte      <= 8'h00;
      output_line_o    <= '0;
      output_line_oe_n <= ~lines_next;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  property p_cmd_clears;
    @(posedge core_clk) disable iff (rst)
    cmd_hit |=> (lines_reg == LINES_RESET) && !lower_sel_reg;
  endproperty
  a_cmd_clears: assert property (p_cmd_clears)
    else $error("command did not clear lines and steering");

  property p_upper_load;
    @(posedge core_clk) disable iff (rst)
    upper_byte_gate |=> lines_reg[15:8] == $past(data_sync_reg) && lower_sel_reg;
  endproperty
  a_upper_load: assert property (p_upper_load)
    else $error("first write did not load upper byte");

  property p_lower_load;
    @(posedge core_clk) disable iff (rst)
    lower_byte_gate |=> lines_reg[7:0] == $past(data_sync_reg) && !lower_sel_reg;
  endproperty
  a_lower_load: assert property (p_lower_load)
    else $error("second write did not load lower byte");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    !write_hit && !cmd_hit |=> $stable(lines_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("lines changed without a write");

  property p_drive;
    @(posedge core_clk) disable iff (rst)
    ##1 output_line_oe_n == ~lines_reg;
  endproperty
  a_drive: assert property (p_drive)
    else $error("line drive does not follow stored bits");

  property p_reply;
    @(posedge core_clk) disable iff (rst)
    write_hit |=> sync_reply [*2];
  endproperty
  a_reply: assert property (p_reply)
    else $error("sync reply missing after selected strobe");

  property p_no_irq;
    @(posedge core_clk) disable iff (rst)
    !irq_req && status_byte == 8'h00;
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("interrupt or status raised");

  property p_deselect;
    @(posedge core_clk) disable iff (rst)
    adr_rise && !addr_match |=> !selected_reg ##1 !sync_reply;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("mismatched address did not deselect");

  property p_strap_capture;
    @(posedge core_clk) disable iff (rst)
    strap_wait_reg == 2'(SYNC_STAGES) && !strap_taken_reg
      |=> strap_taken_reg && dev_num_reg == $past(strap_sync_reg);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("strap value not taken after synchronisation");

  property p_select;
    @(posedge core_clk) disable iff (rst)
    adr_rise && addr_match |=> selected_reg;
  endproperty
  a_select: assert property (p_select)
    else $error("matching address did not select");

  property p_ignore_unselected;
    @(posedge core_clk) disable iff (rst)
    dav_rise && !selected_reg |=> $stable(lines_reg) && $stable(lower_sel_reg);
  endproperty
  a_ignore_unselected: assert property (p_ignore_unselected)
    else $error("write acted while module not selected");

  property p_cmd_ignored;
    @(posedge core_clk) disable iff (rst)
    cmd_rise && !selected_reg |=> $stable(lines_reg) && $stable(lower_sel_reg);
  endproperty
  a_cmd_ignored: assert property (p_cmd_ignored)
    else $error("command acted while module not selected");

  property p_reply_len;
    @(posedge core_clk) disable iff (rst)
    write_hit ##1 !write_hit ##1 !write_hit |=> !sync_reply;
  endproperty
  a_reply_len: assert property (p_reply_len)
    else $error("sync reply stood longer than two cycles");
endmodule
`default_nettype wire

// ===== sim/bus_proc_model.sv
// Processor parallel I/O bus model that drives the output latch
`default_nettype none
module bus_proc_model
(
  input  wire logic       core_clk,
  output logic            address_strobe,
  output logic            data_avail_strobe,
  output logic            cmd_strobe,
  output logic [7:0]      bus_data_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {address_strobe, data_avail_strobe, cmd_strobe} = 3'b000;
    bus_data_line = 8'h00;
  end
  // k: 0 address, 1 output command, 2 write data
  task automatic xfer(input int k, input logic [7:0] d);
    @(negedge core_clk);
    bus_data_line = d;
    repeat (3) @(negedge core_clk);
    case (k)
      0: address_strobe = 1'b1;
      1: cmd_strobe = 1'b1;
      default: data_avail_strobe = 1'b1;
    endcase
    repeat (4) @(negedge core_clk);
    {address_strobe, data_avail_strobe, cmd_strobe} = 3'b000;
    @(negedge core_clk);
    // Released bus must not keep showing the old byte
    bus_data_line = ~d;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic update(input logic [7:0] hi, input logic [7:0] lo);
    xfer(1, 8'h00);
    xfer(2, hi);
    xfer(2, lo);
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking testbench for the sixteen-line output latch
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ctl_line_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  dev_addr_strap = 8'h71;
  wire         address_strobe, data_avail_strobe, cmd_strobe, sync_reply, irq_req;
  wire [7:0]   bus_data_line, status_byte;
  wire [15:0]  output_line_o, output_line_oe_n;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          sync_cycles = 0;
  int          s0;
  always #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) if (sync_reply === 1'b1) sync_cycles++;
  output_latch i_output_latch (.core_clk(core_clk), .rst(rst), .dev_addr_strap(dev_addr_strap),
    .address_strobe(address_strobe), .data_avail_strobe(data_avail_strobe),
    .cmd_strobe(cmd_strobe), .bus_data_line(bus_data_line), .sync_reply(sync_reply),
    .irq_req(irq_req), .status_byte(status_byte), .output_line_o(output_line_o),
    .output_line_oe_n(output_line_oe_n));
  bus_proc_model i_bus_proc_model (.core_clk(core_clk), .address_strobe(address_strobe),
    .data_avail_strobe(data_avail_strobe), .cmd_strobe(cmd_strobe),
    .bus_data_line(bus_data_line));
  //****************************************
  // Checking helpers
  //****************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic expect_lines(input logic [15:0] v);
    check("oe_n", ~v, output_line_oe_n);
    check("line_o", 16'h0000, output_line_o);
    check("irq", 16'h0000, {15'h0000, irq_req});
    check("status", 16'h0000, {8'h00, status_byte});
  endtask
  task automatic do_reset(input logic [7:0] strap);
    @(negedge core_clk);
    rst = 1'b1;
    dev_addr_strap = strap;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    repeat (5) @(negedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  //****************************************
  // Scenarios
  //****************************************
  task automatic pair_test;
    i_bus_proc_model.xfer(0, 8'h71);
    s0 = sync_cycles;
    i_bus_proc_model.update(8'ha5, 8'h3c);
    expect_lines(16'ha53c);
    check("sync", 2 * REPLY_CYCLES, sync_cycles - s0);
    $display("pair_test done");
  endtask
  task automatic steer_back_test;
    i_bus_proc_model.xfer(2, 8'h0f);
    expect_lines(16'h0f3c);
    i_bus_proc_model.xfer(2, 8'hf0);
    repeat (40) @(negedge core_clk);
    expect_lines(16'h0ff0);
    $display("steer_back_test done");
  endtask
  task automatic cmd_mid_test;
    i_bus_proc_model.xfer(2, 8'h11);
    i_bus_proc_model.xfer(1, 8'hff);
    expect_lines(16'h0000);
    i_bus_proc_model.xfer(2, 8'h22);
    expect_lines(16'h2200);
    i_bus_proc_model.xfer(2, 8'h33);
    $display("cmd_mid_test done");
  endtask
  task automatic deselect_test;
    i_bus_proc_model.xfer(0, 8'h12);
    s0 = sync_cycles;
    i_bus_proc_model.xfer(2, 8'h55);
    expect_lines(16'h2233);
    check("sync", 0, sync_cycles - s0);
    i_bus_proc_model.xfer(0, 8'h71);
    i_bus_proc_model.xfer(2, 8'h66);
    expect_lines(16'h6633);
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    expect_lines(16'h0000);
    rst = 1'b0;
    repeat (5) @(negedge core_clk);
    i_bus_proc_model.xfer(2, 8'h77);
    expect_lines(16'h0000);
    $display("deselect_test done");
  endtask
  task automatic strap_test(input logic [7:0] a);
    do_reset(a);
    i_bus_proc_model.xfer(0, a);
    i_bus_proc_model.update(8'h81, 8'h7e);
    expect_lines(16'h817e);
    $display("strap_test done");
  endtask
  initial
  begin
    do_reset(8'h71);
    expect_lines(16'h0000);
    pair_test();
    steer_back_test();
    cmd_mid_test();
    deselect_test();
    strap_test(8'h00);
    strap_test(8'hff);
    report_and_stop();
  end
  initial
  begin
    #(CLK_PERIOD_NS * 5000);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
